// ---- rtl/lsw_pkg.sv ----
// Purpose: Shared constants for the linear sweep and clear controller.
// Assumes: One 100 MHz system clock; registers are 64-bit parallel words.
// Notes:   Register indices are the printed register numbers.
package lsw_pkg;

	localparam int          LSW_CLK_MHZ     = 100;
	localparam int          LSW_ADDR_W      = 4;
	localparam int          LSW_FREQ_W      = 32;
	localparam int          LSW_PHASE_W     = 14;
	localparam int          LSW_RATE_W      = 16;

	localparam logic [3:0]  LSW_REG_LIMITS  = 4'h6;
	localparam logic [3:0]  LSW_REG_STEPS   = 4'h7;
	localparam logic [3:0]  LSW_REG_RATES   = 4'h8;

	// Field positions inside the 64-bit register words.
	localparam int          LSW_END_LSB     = 32;
	localparam int          LSW_START_LSB   = 0;
	localparam int          LSW_FALL_LSB    = 32;
	localparam int          LSW_RISE_LSB    = 0;
	localparam int          LSW_FRATE_LSB   = 16;
	localparam int          LSW_RRATE_LSB   = 0;

	localparam logic [63:0] LSW_RST_LIMITS  = 64'h0;
	localparam logic [63:0] LSW_RST_STEPS   = 64'h0;
	localparam logic [31:0] LSW_RST_RATES   = 32'h0;
	localparam logic [2:0]  LSW_RST_CODE    = 3'h0;
	localparam logic        LSW_RST_UP      = 1'b1;

	// Phase words sit in the top bits; this keeps only those bits.
	localparam logic [31:0] LSW_PHASE_MASK  = 32'hfffc0000;
	localparam logic [31:0] LSW_FULL_MASK   = 32'hffffffff;

	localparam logic [1:0]  LSW_DEST_FREQ   = 2'h0;
	localparam logic [1:0]  LSW_DEST_PHASE  = 2'h1;

	localparam logic [1:0]  LSW_DIR_OFF     = 2'h0;
	localparam logic [1:0]  LSW_DIR_UP      = 2'h1;
	localparam logic [1:0]  LSW_DIR_DOWN    = 2'h2;
	localparam logic [1:0]  LSW_DIR_BIDI    = 2'h3;

	typedef enum logic [4:0] {
		LSW_ST_IDLE = 5'b00001,
		LSW_ST_CLR  = 5'b00010,
		LSW_ST_UP   = 5'b00100,
		LSW_ST_DOWN = 5'b01000,
		LSW_ST_HOLD = 5'b10000
	} lsw_state_t;

endpackage

// ---- rtl/lsw_step_timer.sv ----
// Purpose: Step interval timer; pulses once every interval system clocks.
// Assumes: The interval input may change at any time.
// Notes:   A zero interval is treated as one cycle.
module lsw_step_timer
	import lsw_pkg::*;
#(
	parameter int RATE_W = LSW_RATE_W
) (
	input  wire logic              i_clock,
	input  wire logic              i_arst_n,
	input  wire logic              i_load,
	input  wire logic              i_run,
	input  wire logic [RATE_W-1:0] i_interval,
	output logic                   o_expire
);

	typedef struct packed {
		logic [RATE_W-1:0] cnt;
		logic              exp;
	} lsw_tmr_t;

	lsw_tmr_t          s_q;
	lsw_tmr_t          s_d;
	logic [RATE_W-1:0] reload;

	always_comb begin
		// A new interval only takes effect at the next reload.
		reload = (i_interval == '0) ? '0 : i_interval - 1'b1;
		s_d = s_q;
		s_d.exp = 1'b0;
		if (i_load) begin
			s_d.cnt = reload;
		end else if (i_run) begin
			if (s_q.cnt == '0) begin
				s_d.exp = 1'b1;
				s_d.cnt = reload;
			end else begin
				s_d.cnt = s_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_expire = s_q.exp;

endmodule

// ---- rtl/lsw_sweep_ctrl.sv ----
// Purpose: Linear sweep auxiliary accumulator with clear controls.
// Assumes: Control bits arrive as synchronous levels from a control word.
// Notes:   Register writes take effect at once, even mid-sweep.
module lsw_sweep_ctrl
	import lsw_pkg::*;
#(
	parameter int WORD_W = LSW_FREQ_W,
	parameter int RATE_W = LSW_RATE_W
) (
	input  wire logic              i_clock,
	input  wire logic              i_arst_n,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	input  wire logic [3:0]        i_reg_addr,
	input  wire logic [63:0]       i_reg_wdata,
	input  wire logic              i_io_update,
	input  wire logic              i_serial_mode,
	input  wire logic              i_profile_from_pins,
	input  wire logic [2:0]        i_profile_bits,
	input  wire logic [2:0]        i_profile_select_pins,
	input  wire logic              i_aux_acc_enable,
	input  wire logic [1:0]        i_destination,
	input  wire logic              i_level_trigger,
	input  wire logic              i_no_dwell,
	input  wire logic              i_clear_aux_cont,
	input  wire logic              i_clear_phase_cont,
	input  wire logic              i_autoclear_aux,
	input  wire logic              i_autoclear_phase,
	output logic [63:0]            o_reg_rdata,
	output logic [WORD_W-1:0]      o_sweep_word,
	output logic                   o_drive_freq,
	output logic                   o_drive_phase,
	output logic                   o_phase_acc_clear,
	output logic                   o_sweep_busy
);

	// One registered copy of every piece of controller state except the step timer's own count and expire flag.
	typedef struct packed {
		lsw_state_t        st;
		logic [WORD_W-1:0] acc;
		logic [63:0]       limits;
		logic [63:0]       steps;
		logic [31:0]       rates;
		logic [2:0]        prev_code;
		logic              going_up;
		logic              tmr_load;
		logic [63:0]       rdata;
		logic              to_freq;
		logic              to_phase;
		logic              ph_clr;
		logic              busy;
	} lsw_regs_t;

	lsw_regs_t         s_q;
	lsw_regs_t         s_d;
	logic [2:0]        code;
	logic [1:0]        dir;
	logic              trigger;
	logic              is_phase;
	logic [WORD_W-1:0] mask;
	logic [WORD_W-1:0] lim_end;
	logic [WORD_W-1:0] lim_start;
	logic [WORD_W-1:0] step_rise;
	logic [WORD_W-1:0] step_fall;
	logic [WORD_W:0]   sum_up;
	logic [WORD_W:0]   diff_dn;
	logic [RATE_W-1:0] interval;
	logic              tmr_expire;
	logic              restart_up;
	logic              restart_dn;
	logic              tmr_run;
	logic              code_changed;
	logic              is_freq;
	logic              hit_end;
	logic              hit_start;

	// The timer is reloaded at every start and turnaround, so a new
	// interval word is picked up by the next step.
	lsw_step_timer #(
		.RATE_W (RATE_W)
	) u_timer (
		.i_clock    (i_clock),
		.i_arst_n   (i_arst_n),
		.i_load     (s_q.tmr_load),
		.i_run      (tmr_run),
		.i_interval (interval),
		.o_expire   (tmr_expire)
	);

	always_comb begin
		// Pins can only steer the sweep in serial mode.
		if (i_serial_mode && i_profile_from_pins) begin
			code = i_profile_select_pins;
		end else begin
			code = i_profile_bits;
		end
		dir = code[1:0];
		// Any change of the active code counts, as does the strobe.
		code_changed = (code != s_q.prev_code);
		trigger = i_io_update || code_changed;
		tmr_run = (s_q.st == LSW_ST_UP) || (s_q.st == LSW_ST_DOWN);
		is_freq = (i_destination == LSW_DEST_FREQ);
		is_phase = (i_destination == LSW_DEST_PHASE);
		// Phase sweeps keep only the top bits of every word and limit.
		if (is_phase) begin
			mask = LSW_PHASE_MASK[WORD_W-1:0];
		end else begin
			mask = LSW_FULL_MASK[WORD_W-1:0];
		end

		lim_end   = s_q.limits[LSW_END_LSB +: WORD_W] & mask;
		lim_start = s_q.limits[LSW_START_LSB +: WORD_W] & mask;
		step_rise = s_q.steps[LSW_RISE_LSB +: WORD_W] & mask;
		step_fall = s_q.steps[LSW_FALL_LSB +: WORD_W] & mask;
		// The interval follows the present direction of travel.
		if (s_q.going_up) begin
			interval = s_q.rates[LSW_RRATE_LSB +: RATE_W];
		end else begin
			interval = s_q.rates[LSW_FRATE_LSB +: RATE_W];
		end

		sum_up  = {1'b0, s_q.acc} + {1'b0, step_rise};
		diff_dn = {1'b0, s_q.acc} - {1'b0, step_fall};
		// A carry means the host let it overflow; it then wraps freely.
		hit_end   = !sum_up[WORD_W] && (sum_up[WORD_W-1:0] >= lim_end);
		// A borrow means the step went past zero, so it counts as start.
		hit_start = diff_dn[WORD_W] || (diff_dn[WORD_W-1:0] <= lim_start);

		// Level mode restarts only while the matching profile bit is high.
		restart_up = i_level_trigger && code[0];
		restart_dn = i_level_trigger && code[1];

		s_d = s_q;
		s_d.prev_code = code;
		s_d.tmr_load = 1'b0;
		s_d.rdata = '0;
		s_d.to_freq = i_aux_acc_enable && is_freq;
		s_d.to_phase = i_aux_acc_enable && is_phase;
		// Phase clear is independent of anything done to the aux side.
		s_d.ph_clr = i_clear_phase_cont
			|| (i_autoclear_phase && trigger);

		// Writes land at once, so a sweep in flight picks up new words.
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				LSW_REG_LIMITS: s_d.limits = i_reg_wdata;
				LSW_REG_STEPS:  s_d.steps = i_reg_wdata;
				LSW_REG_RATES:  s_d.rates = i_reg_wdata[31:0];
				default: ;
			endcase
		end
		// Read data stands for one cycle after the strobe, else zero.
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				LSW_REG_LIMITS: s_d.rdata = s_q.limits;
				LSW_REG_STEPS:  s_d.rdata = s_q.steps;
				LSW_REG_RATES:  s_d.rdata = {32'h0, s_q.rates};
				default:        s_d.rdata = '0;
			endcase
		end

		// Disable and continuous clear override every trigger.
		if (!i_aux_acc_enable || i_clear_aux_cont) begin
			s_d.st = LSW_ST_IDLE;
			s_d.acc = '0;
		end else if (trigger && i_autoclear_aux) begin
			// Clear for one cycle, then release into the requested sweep.
			s_d.st = LSW_ST_CLR;
			s_d.acc = '0;
		end else if (trigger || s_q.st == LSW_ST_CLR) begin
			unique case (dir)
				LSW_DIR_UP, LSW_DIR_BIDI: begin
					s_d.st = LSW_ST_UP;
					s_d.acc = lim_start;
					s_d.going_up = 1'b1;
					s_d.tmr_load = 1'b1;
				end
				LSW_DIR_DOWN: begin
					// Ramp down begins wherever the accumulator stands.
					s_d.st = LSW_ST_DOWN;
					s_d.going_up = 1'b0;
					s_d.tmr_load = 1'b1;
				end
				default: begin
					s_d.st = LSW_ST_IDLE;
				end
			endcase
		end else begin
			unique case (s_q.st)
				LSW_ST_UP: begin
					if (tmr_expire) begin
						if (hit_end) begin
							// No-dwell drops straight back to zero here.
							s_d.acc = i_no_dwell ? '0 : lim_end;
							// Bidirectional mode turns round at the limit.
							if (dir == LSW_DIR_BIDI) begin
								s_d.st = LSW_ST_DOWN;
								s_d.going_up = 1'b0;
								s_d.tmr_load = 1'b1;
							end else begin
								s_d.st = LSW_ST_HOLD;
							end
						end else begin
							s_d.acc = sum_up[WORD_W-1:0];
						end
					end
				end
				LSW_ST_DOWN: begin
					if (tmr_expire) begin
						if (hit_start) begin
							s_d.acc = lim_start;
							// Bidirectional mode turns round at the limit.
							if (dir == LSW_DIR_BIDI) begin
								s_d.st = LSW_ST_UP;
								s_d.going_up = 1'b1;
								s_d.tmr_load = 1'b1;
							end else begin
								s_d.st = LSW_ST_HOLD;
							end
						end else begin
							s_d.acc = diff_dn[WORD_W-1:0];
						end
					end
				end
				LSW_ST_HOLD: begin
					if (dir == LSW_DIR_UP && restart_up) begin
						// A level restart upwards begins at the start limit.
						s_d.st = LSW_ST_UP;
						s_d.acc = lim_start;
						s_d.going_up = 1'b1;
						s_d.tmr_load = 1'b1;
					end else if (dir == LSW_DIR_DOWN && restart_dn) begin
						// A level restart downwards begins at the end limit.
						s_d.st = LSW_ST_DOWN;
						s_d.acc = lim_end;
						s_d.going_up = 1'b0;
						s_d.tmr_load = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// Busy is registered so the pin never sees a state decode glitch.
		s_d.busy = (s_d.st == LSW_ST_UP) || (s_d.st == LSW_ST_DOWN);
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q <= '{
				st:        LSW_ST_IDLE,
				acc:       '0,
				limits:    LSW_RST_LIMITS,
				steps:     LSW_RST_STEPS,
				rates:     LSW_RST_RATES,
				prev_code: LSW_RST_CODE,
				going_up:  LSW_RST_UP,
				tmr_load:  1'b0,
				rdata:     64'h0,
				to_freq:   1'b0,
				to_phase:  1'b0,
				ph_clr:    1'b0,
				busy:      1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_reg_rdata       = s_q.rdata;
	assign o_sweep_word      = s_q.acc;
	assign o_drive_freq      = s_q.to_freq;
	assign o_drive_phase     = s_q.to_phase;
	assign o_phase_acc_clear = s_q.ph_clr;
	assign o_sweep_busy      = s_q.busy;

endmodule

// ---- tb/dds_linear_sweep_clear_ctrl_bench.sv ----
// Purpose: Self-checking bench for the sweep controller.
// Assumes: 100 MHz clock; a host model drives pins and update.
// Notes:   Expected sweeps come from an integer model.
module dds_linear_sweep_clear_ctrl_bench
	import lsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ur = 0, ser = 0;
	logic        pfp = 0, en = 0, lvl = 0, nd = 0, cac = 0, cpc = 0;
	logic        aaa = 0, aap = 0, upd, dfr, dph, pclr, busy;
	logic [3:0]  addr = 0, dly = 0;
	logic [2:0]  pb = 0, pr = 0, pins;
	logic [1:0]  dest = 0;
	logic [63:0] wd = 0, rdata;
	logic [31:0] word, rnd = 32'h6, s, e, r, f;
	logic [31:0] q[$];
	int          errors = 0, tests_run = 0;
	always #5 clk = ~clk;
	lsw_host_model host (.i_clock(clk), .i_pins(pr), .i_update(ur),
		.i_delay(dly), .o_profile_select_pins(pins), .o_io_update(upd));
	lsw_sweep_ctrl DUT (.i_clock(clk), .i_arst_n(rst_n), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
		.i_io_update(upd), .i_serial_mode(ser), .i_profile_from_pins(pfp),
		.i_profile_bits(pb), .i_profile_select_pins(pins),
		.i_aux_acc_enable(en), .i_destination(dest), .i_level_trigger(lvl),
		.i_no_dwell(nd), .i_clear_aux_cont(cac), .i_clear_phase_cont(cpc),
		.i_autoclear_aux(aaa), .i_autoclear_phase(aap), .o_reg_rdata(rdata),
		.o_sweep_word(word), .o_drive_freq(dfr), .o_drive_phase(dph),
		.o_phase_acc_clear(pclr), .o_sweep_busy(busy));
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic check(string n, logic [63:0] x, logic [63:0] g);
		tests_run++;
		if (g !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wreg(logic [3:0] a, logic [63:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(logic [3:0] a, logic [63:0] x);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 check("rdata", x, rdata);
		@(posedge clk);
		#1 check("rdata idle", 64'h0, rdata);
	endtask
	// Limits overshot by a step are clamped, as the controller does.
	function automatic void up_seq(logic [31:0] m, bit z);
		longint v = s & m;
		q.push_back(v);
		while (v < (e & m)) begin
			v = v + (r & m);
			if (v >= (e & m)) v = e & m;
			q.push_back(v);
		end
		if (z) q[$] = 0;
	endfunction
	function automatic void dn_seq(logic [31:0] m);
		longint v = e & m;
		while (v > (s & m)) begin
			v = v - (f & m);
			if (v <= (s & m)) v = s & m;
			q.push_back(v);
		end
	endfunction
	task automatic run_seq(int n, bit stop);
		int tm[$];
		logic [31:0] last;
		logic [31:0] want;
		last = word;
		if (q.size() > 0 && q[0] === word) void'(q.pop_front());
		for (int c = 0; c < 90 && !(stop && q.size() == 0); c++) begin
			@(posedge clk);
			#1;
			if (word !== last) begin
				want = q.size() ? q.pop_front() : last;
				check("sweep word", want, word);
				tm.push_back(c);
				last = word;
			end
		end
		check("steps left", 0, q.size());
		if (n > 0 && tm.size() > 3) begin
			check("step time", n, tm[3] - tm[2]);
		end
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		for (int i = 6; i < 10; i++) begin
			rreg(i[3:0], 64'h0);
			rnd = xs(rnd);
			wreg(i[3:0], {rnd, xs(rnd)});
			rreg(i[3:0], i == 9 ? 64'h0 : i == 8 ? {32'h0, xs(rnd)} :
				{rnd, xs(rnd)});
		end
		r = 32'd20 + rnd % 30;
		f = r + 3;
		s = 32'h100;
		e = s + 5 * r + 7;
		wreg(LSW_REG_LIMITS, {e, s});
		wreg(LSW_REG_STEPS, {f, r});
		wreg(LSW_REG_RATES, 64'h2_0003);
		en <= 1;
		pb <= 3'b101;
		up_seq(LSW_FULL_MASK, 0);
		run_seq(3, 0);
		pr <= 3'b010;
		run_seq(0, 0);
		ser <= 1;
		pfp <= 1;
		dn_seq(LSW_FULL_MASK);
		run_seq(2, 0);
		ser <= 0;
		up_seq(LSW_FULL_MASK, 0);
		run_seq(3, 0);
		nd <= 1;
		aaa <= 1;
		aap <= 1;
		dly <= 4'h3;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			ur <= 1;
			@(posedge clk);
			ur <= 0;
			q.push_back(0);
			up_seq(LSW_FULL_MASK, 1);
			run_seq(3, 0);
		end
		nd <= 0;
		aaa <= 0;
		aap <= 0;
		pb <= 3'b011;
		up_seq(LSW_FULL_MASK, 0);
		dn_seq(LSW_FULL_MASK);
		run_seq(3, 1);
		s = 32'h0004_1234;
		e = 32'h0010_ffff;
		r = 32'h0005_1111;
		wreg(LSW_REG_LIMITS, {e, s});
		wreg(LSW_REG_STEPS, {f, r});
		dest <= LSW_DEST_PHASE;
		pb <= 3'b001;
		up_seq(LSW_PHASE_MASK, 0);
		run_seq(3, 0);
		check("drive phase", 1, dph);
		@(posedge clk);
		cac <= 1;
		repeat (2) @(posedge clk);
		#1 check("cleared", 0, word);
		check("phase clr", 0, pclr);
		@(posedge clk);
		cac <= 0;
		cpc <= 1;
		en <= 0;
		repeat (2) @(posedge clk);
		#1 check("phase clr", 1, pclr);
		check("disabled", 0, busy);
		@(posedge clk);
		cpc <= 0;
		en <= 1;
		dest <= LSW_DEST_FREQ;
		pb <= 3'b100;
		repeat (3) @(posedge clk);
		#1 check("sweep off", 0, busy);
		check("drive freq", 1, dfr);
		@(posedge clk);
		lvl <= 1;
		pb <= 3'b001;
		up_seq(LSW_FULL_MASK, 0);
		up_seq(LSW_FULL_MASK, 0);
		run_seq(3, 1);
		end_sim();
	end
endmodule

// ---- tb/lsw_host_model.sv ----
// Purpose: Host model driving the profile pins and update strobe.
// Assumes: Requests arrive just after a clock edge.
// Notes:   A delay input makes it answer update requests promptly or slowly.
module lsw_host_model (
	input  wire logic       i_clock,
	input  wire logic [2:0] i_pins,
	input  wire logic       i_update,
	input  wire logic [3:0] i_delay,
	output logic      [2:0] o_profile_select_pins = 3'h0,
	output logic            o_io_update = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q = 4'h0;
	logic       pend_q = 1'b0;
	always @(posedge i_clock) begin
		o_profile_select_pins <= i_pins;
		o_io_update <= pend_q && wait_q == 4'h0;
		if (i_update) begin
			pend_q <= 1'b1;
			wait_q <= i_delay;
		end else if (wait_q != 4'h0)
			wait_q <= wait_q - 4'h1;
		else
			pend_q <= 1'b0;
	end
endmodule

// ---- tb/lsw_sweep_sva.sv ----
// Purpose: Port assertions for the sweep controller.
// Assumes: One clock; reset is asynchronous and active low.
// Notes:   Outputs are registered, so effects show a cycle later.
module lsw_sweep_sva
	import lsw_pkg::*;
#(
	parameter int WORD_W = LSW_FREQ_W
) (
	input wire logic              i_clock,
	input wire logic              i_arst_n,
	input wire logic              i_io_update,
	input wire logic              i_aux_acc_enable,
	input wire logic [1:0]        i_destination,
	input wire logic              i_clear_aux_cont,
	input wire logic              i_clear_phase_cont,
	input wire logic              i_autoclear_aux,
	input wire logic              i_autoclear_phase,
	input wire logic [WORD_W-1:0] o_sweep_word,
	input wire logic              o_drive_freq,
	input wire logic              o_drive_phase,
	input wire logic              o_phase_acc_clear,
	input wire logic              o_sweep_busy
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	property p_hold;
		i_clear_aux_cont |=> o_sweep_word == '0 && !o_sweep_busy;
	endproperty
	a_hold: assert property (p_hold) else $error("acc not held");
	property p_off;
		!i_aux_acc_enable |=> o_sweep_word == '0 && !o_sweep_busy;
	endproperty
	a_off: assert property (p_off) else $error("acc not off");
	property p_busy;
		o_sweep_busy |-> $past(i_aux_acc_enable) && !$past(i_clear_aux_cont);
	endproperty
	a_busy: assert property (p_busy) else $error("busy");
	// Two settled cycles are needed before the drive flags follow inputs.
	property p_dest;
		$past(i_arst_n) && $past(i_arst_n, 2) |->
			o_drive_freq == ($past(i_aux_acc_enable) &&
			$past(i_destination) == LSW_DEST_FREQ) &&
			o_drive_phase == ($past(i_aux_acc_enable) &&
			$past(i_destination) == LSW_DEST_PHASE);
	endproperty
	a_dest: assert property (p_dest) else $error("drive");
	property p_pcont;
		i_clear_phase_cont |=> o_phase_acc_clear;
	endproperty
	a_pcont: assert property (p_pcont) else $error("pclr");
	property p_pidle;
		!i_clear_phase_cont && !i_autoclear_phase |=> !o_phase_acc_clear;
	endproperty
	a_pidle: assert property (p_pidle) else $error("pclr idle");
	property p_ppulse;
		i_autoclear_phase && i_io_update |=> o_phase_acc_clear;
	endproperty
	a_ppulse: assert property (p_ppulse) else $error("pclr pulse");
	property p_aclr;
		i_autoclear_aux && i_io_update && i_aux_acc_enable &&
			!i_clear_aux_cont |=> o_sweep_word == '0;
	endproperty
	a_aclr: assert property (p_aclr) else $error("auto clear");
endmodule

bind lsw_sweep_ctrl lsw_sweep_sva #(.WORD_W(WORD_W)) u_sva (
	.i_clock(i_clock), .i_arst_n(i_arst_n), .i_io_update(i_io_update),
	.i_aux_acc_enable(i_aux_acc_enable), .i_destination(i_destination),
	.i_clear_aux_cont(i_clear_aux_cont), .i_autoclear_aux(i_autoclear_aux),
	.i_clear_phase_cont(i_clear_phase_cont), .o_sweep_word(o_sweep_word),
	.i_autoclear_phase(i_autoclear_phase), .o_drive_freq(o_drive_freq),
	.o_drive_phase(o_drive_phase), .o_phase_acc_clear(o_phase_acc_clear),
	.o_sweep_busy(o_sweep_busy));
